// ### inc/tag_pkg.sv
// constants for the stop input edge tagging block
// assumes a 200 MHz hclk and an AHB-Lite slave with 32-bit data
package tag_pkg;
    localparam int NUM_IN = 6;
    localparam int TIME_W = 28;
    localparam int CNT_W = 32;
    // register byte offsets
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_EDGE = 8'h04;
    localparam logic [7:0] OFF_DELAY = 8'h08;
    localparam logic [7:0] OFF_CTRL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_EVENT = 8'h1c;
    localparam logic [7:0] OFF_CFT = 8'h20;
    localparam logic [7:0] OFF_ROI_BASE = 8'h40;
    localparam logic [7:0] ROI_STRIDE = 8'h10;
    // edge selection codes, two bits per input
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_CFT = 2'h3;
    // event word layout
    localparam int EV_CH_LSB = 0;
    localparam int EV_EDGE_BIT = 3;
    localparam int EV_TIME_LSB = 4;
    // common delay
    localparam real DELAY_STEP_NS = 3.2;
    localparam real DELAY_MAX_NS = 48.0;
    localparam real CLK_NS = 5.0;
    localparam int DELAY_STEPS = 15;
    localparam int DELAY_W = 4;
    localparam int DELAY_MAX_CYC = (DELAY_MAX_NS + CLK_NS - 0.001) / CLK_NS;
    localparam int FRAC_W = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage : tag_pkg

// ### hw/delay_line.sv
// shift-register delay for the six input levels
// assumes inputs already synchronised to hclk
module delay_line
    import tag_pkg::*;
#(
    parameter int WIDTH = NUM_IN,
    parameter int DEPTH = 16
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] din,
    input wire logic [$clog2(DEPTH)-1:0] sel,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] tap_r [DEPTH];
    wire [WIDTH-1:0] pick = (sel == '0) ? din : tap_r[sel - 1'b1];

    // taps shift every cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < DEPTH; i++) tap_r[i] <= '0;
            dout <= '0;
        end
        else
        begin
            tap_r[0] <= din;
            for (int i = 1; i < DEPTH; i++) tap_r[i] <= tap_r[i-1];
            dout <= pick;
        end
    end
endmodule : delay_line

// ### hw/edge_tag.sv
// stop input edge tagging: enable, edge select, delay, region count, cft
// assumes pins asynchronous to hclk; single AHB-Lite master
// Operation
// RULE1 - each of six inputs has its own enable; disabled input yields no events
// RULE2 - each input selects falling, rising, or both edges
// RULE3 - event word bit 3 is one for falling edge, zero for rising
// RULE4 - one common delay for all inputs, 3.2 ns steps up to 48 ns; code rounds each setting up to whole 5 ns cycles, 50 ns at 15 steps
// RULE5 - region preset counts events in [low,high); stop once count exceeds preset
// RULE6 - region limits are compared unchanged even outside the spectrum range
// RULE7 - both-edges pulse width from paired edges; polarity picks under or over threshold
// RULE8 - cft peak time at programmed fraction of edge interval
// RULE9 - cft pairs wider than max width give no peak estimate
// RULE10 - user keeps rate low so both edges of every pulse are seen
// RULE11 - delay setting is step count, zero means no added delay
module edge_tag
    import tag_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_IN-1:0] tof_in,
    input wire logic meas_start,
    output logic event_valid,
    output logic [31:0] event_word,
    output logic [TIME_W-1:0] peak_time,
    output logic peak_valid,
    output logic meas_running,
    output logic irq
);
    // ********************************
    // register state
    // ********************************
    logic [NUM_IN-1:0] enable_r;
    logic [2*NUM_IN-1:0] edge_r;
    logic [NUM_IN-1:0] pol_r;
    logic [DELAY_W-1:0] delay_r;
    logic [NUM_IN-1:0] roi_en_r;
    logic [CNT_W-1:0] preset_r [NUM_IN];
    logic [TIME_W-1:0] roi_lo_r [NUM_IN];
    logic [TIME_W-1:0] roi_hi_r [NUM_IN];
    logic [CNT_W-1:0] roi_cnt_r [NUM_IN];
    logic [FRAC_W-1:0] frac_r;
    logic [TIME_W-1:0] max_w_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [TIME_W-1:0] time_r;
    logic run_r;

    // ********************************
    // input synchronisers and delay
    // ********************************
    logic [NUM_IN-1:0] sync1_r;
    logic [NUM_IN-1:0] sync2_r;
    logic [NUM_IN-1:0] dly_in;
    logic [NUM_IN-1:0] prev_r;

    // two flops before any logic
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            sync1_r <= tof_in;
            sync2_r <= sync1_r;
            prev_r <= dly_in;
        end
    end

    // delay counts: 3.2 ns steps rounded up to whole 5 ns cycles, zero stays zero
    wire [3:0] dly_cyc = 4'((32'(delay_r) * 32 + 49) / 50);

    // RULE4 common delay
    // RULE11 zero is no delay
    delay_line #(.WIDTH(NUM_IN), .DEPTH(16)) u_dly (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(sync2_r),
        .sel(dly_cyc),
        .dout(dly_in)
    );

    // ********************************
    // edge detection per input
    // ********************************
    logic [NUM_IN-1:0] rise_w;
    logic [NUM_IN-1:0] fall_w;
    logic [NUM_IN-1:0] hit_w;
    logic [NUM_IN-1:0] in_roi_w;
    genvar g;
    generate
        for (g = 0; g < NUM_IN; g++)
        begin : g_edge
            wire [1:0] mode = edge_r[2*g +: 2];
            assign rise_w[g] = dly_in[g] & ~prev_r[g];
            assign fall_w[g] = ~dly_in[g] & prev_r[g];
            // RULE1 enable gate
            // RULE2 edge select
            assign hit_w[g] = enable_r[g] & run_r & (
                (mode == EDGE_FALL & fall_w[g]) |
                (mode == EDGE_RISE & rise_w[g]) |
                (mode[1] & (rise_w[g] | fall_w[g])));
            // RULE5 region window
            // RULE6 limits used unchanged
            assign in_roi_w[g] = (time_r >= roi_lo_r[g]) & (time_r < roi_hi_r[g]);
        end
    endgenerate
    // lowest numbered hit wins the output port this cycle
    logic [2:0] pick_ch;
    logic any_hit;
    always_comb
    begin
        pick_ch = 3'h0;
        any_hit = 1'b0;
        for (int i = NUM_IN - 1; i >= 0; i--)
            if (hit_w[i])
            begin
                pick_ch = 3'(i);
                any_hit = 1'b1;
            end
    end
    wire pick_fall = fall_w[pick_ch];
    // RULE3 edge flag in bit 3
    wire [31:0] word_nxt = {time_r, pick_fall, pick_ch};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            event_valid <= 1'b0;
            event_word <= '0;
        end
        else
        begin
            event_valid <= any_hit;
            event_word <= any_hit ? word_nxt : event_word;
        end
    end

    // ********************************
    // pulse width pairing and cft, on whichever both-edges input wins the output port
    // ********************************
    logic [TIME_W-1:0] first_t_r;
    logic pair_open_r;
    wire [1:0] cm = edge_r[2*pick_ch +: 2];
    // RULE7 polarity: under threshold opens on falling, over on rising
    wire opens = any_hit & cm[1] & (pol_r[pick_ch] ? ~pick_fall : pick_fall);
    wire closes = any_hit & cm[1] & pair_open_r & ~opens;
    wire [TIME_W-1:0] width = time_r - first_t_r;
    // peak = first + width / (1 + ratio); ratio in 4.4 fixed point
    wire [TIME_W+4:0] num = {1'b0, width, 4'h0};
    wire [TIME_W+4:0] den = 33'(frac_r) + 33'd16;
    wire [TIME_W-1:0] peak_off = TIME_W'(num / den);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pair_open_r <= 1'b0;
            first_t_r <= '0;
            peak_valid <= 1'b0;
            peak_time <= '0;
        end
        else
        begin
            peak_valid <= 1'b0;
            if (opens)
            begin
                pair_open_r <= 1'b1;
                first_t_r <= time_r;
            end
            else if (closes)
            begin
                pair_open_r <= 1'b0;
                // RULE8 fraction estimate
                // RULE9 reject too wide
                if (cm == EDGE_CFT && width <= max_w_r)
                begin
                    peak_valid <= 1'b1;
                    peak_time <= first_t_r + peak_off;
                end
            end
        end
    end

    // ********************************
    // timebase, run and region counters
    // ********************************
    logic [NUM_IN-1:0] preset_hit;
    generate
        for (g = 0; g < NUM_IN; g++)
        begin : g_cnt
            assign preset_hit[g] = roi_en_r[g] & (roi_cnt_r[g] > preset_r[g]);
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    roi_cnt_r[g] <= '0;
                else if (meas_start)
                    roi_cnt_r[g] <= '0;
                else if (hit_w[g] & roi_en_r[g] & in_roi_w[g])
                    roi_cnt_r[g] <= roi_cnt_r[g] + 1'b1;
            end
        end
    endgenerate

    // RULE5 stop on preset exceeded
    wire stop_now = run_r & (|preset_hit);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            run_r <= 1'b0;
            time_r <= '0;
            meas_running <= 1'b0;
        end
        else
        begin
            if (meas_start)
            begin
                run_r <= 1'b1;
                time_r <= '0;
            end
            else
            begin
                if (stop_now)
                    run_r <= 1'b0;
                if (run_r)
                    time_r <= time_r + 1'b1;
            end
            meas_running <= run_r;
        end
    end

    // ********************************
    // AHB-Lite slave
    // ********************************
    logic dp_wr_r;
    logic [7:0] dp_addr_r;
    wire take = hsel & hready & htrans[1];
    wire [7:0] roi_off = dp_addr_r - OFF_ROI_BASE;
    wire roi_sel = dp_addr_r >= OFF_ROI_BASE && roi_off < 8'(NUM_IN) * ROI_STRIDE;
    wire [2:0] ri = 3'(roi_off >> 4);
    wire [1:0] rf = roi_off[3:2];
    // events: run start, preset stop, cft reject
    wire [2:0] ev_set = {closes & cm == EDGE_CFT & width > max_w_r, stop_now, meas_start};
    wire [2:0] w1c = (dp_wr_r && dp_addr_r == OFF_IRQ_STAT) ? hwdata[2:0] : 3'h0;
    // reads decode the address phase so hrdata stands through the data phase
    wire [7:0] rd_off = haddr[7:0] - OFF_ROI_BASE;
    wire rd_roi = haddr[7:0] >= OFF_ROI_BASE && rd_off < 8'(NUM_IN) * ROI_STRIDE;
    wire [2:0] rd_ri = 3'(rd_off >> 4);
    logic [31:0] rd_w;
    always_comb
    begin
        rd_w = 32'h0;
        case (haddr[7:0])
            OFF_ENABLE: rd_w = 32'(enable_r);
            OFF_EDGE: rd_w = 32'(edge_r);
            OFF_DELAY: rd_w = 32'(delay_r);
            OFF_CTRL: rd_w = {18'h0, pol_r, 2'h0, roi_en_r};
            OFF_STATUS: rd_w = {25'h0, run_r, preset_hit};
            OFF_IRQ_STAT: rd_w = 32'(irq_stat_r);
            OFF_IRQ_MASK: rd_w = 32'(irq_mask_r);
            OFF_EVENT: rd_w = event_word;
            OFF_CFT: rd_w = {max_w_r[23:0], frac_r};
            default:
                if (rd_roi)
                    case (rd_off[3:2])
                        2'h0: rd_w = preset_r[rd_ri];
                        2'h1: rd_w = 32'(roi_lo_r[rd_ri]);
                        2'h2: rd_w = 32'(roi_hi_r[rd_ri]);
                        default: rd_w = roi_cnt_r[rd_ri];
                    endcase
        endcase
    end

    // address phase capture, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq_stat_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            dp_wr_r <= take & hwrite;
            if (take)
                dp_addr_r <= haddr[7:0];
            // read data registered for the next data phase
            hrdata <= (take & ~hwrite) ? rd_w : hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            // set wins over write-one clear
            irq_stat_r <= (irq_stat_r & ~w1c) | ev_set;
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            enable_r <= '0;
            edge_r <= '0;
            pol_r <= '0;
            delay_r <= '0;
            roi_en_r <= '0;
            frac_r <= '0;
            max_w_r <= '0;
            irq_mask_r <= '0;
            for (int i = 0; i < NUM_IN; i++)
            begin
                preset_r[i] <= '0;
                roi_lo_r[i] <= '0;
                roi_hi_r[i] <= '0;
            end
        end
        else if (dp_wr_r)
        begin
            case (dp_addr_r)
                OFF_ENABLE: enable_r <= hwdata[NUM_IN-1:0];
                OFF_EDGE: edge_r <= hwdata[2*NUM_IN-1:0];
                // four bits cap the setting at 15 steps, i.e. 48 ns
                OFF_DELAY: delay_r <= hwdata[DELAY_W-1:0];
                OFF_CTRL:
                begin
                    roi_en_r <= hwdata[5:0];
                    pol_r <= hwdata[13:8];
                end
                OFF_IRQ_MASK: irq_mask_r <= hwdata[2:0];
                OFF_CFT:
                begin
                    frac_r <= hwdata[7:0];
                    max_w_r <= TIME_W'(hwdata[31:8]);
                end
                default:
                    if (roi_sel)
                        case (rf)
                            2'h0: preset_r[ri] <= hwdata;
                            2'h1: roi_lo_r[ri] <= hwdata[TIME_W-1:0];
                            2'h2: roi_hi_r[ri] <= hwdata[TIME_W-1:0];
                            default: ;
                        endcase
            endcase
        end
    end
endmodule : edge_tag

// ### test/tag_checker.sv
// concurrent checks on the edge_tag ports
// assumes bound to edge_tag; one hclk domain
module tag_checker
    import tag_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NUM_IN-1:0] tof_in,
    input wire logic meas_start,
    input wire logic event_valid,
    input wire logic [31:0] event_word,
    input wire logic peak_valid,
    input wire logic meas_running
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_IN-1:0] tof_q;
    logic [5:0] quiet_r;
    logic [TIME_W-1:0] last_t_r;
    logic unm_r;
    // ****************************************
    // helper logic
    // ****************************************
    // holes between the cft word and the region block, and above it
    wire unm_addr = haddr[31:8] == 24'h0 && ((haddr[7:0] >= 8'h24 && haddr[7:0] < 8'h40) || haddr[7:0] >= 8'ha0);
    wire rd_take = hsel && hready && htrans[1] && !hwrite;
    // quiet counter saturates so a long quiet spell never wraps
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tof_q <= '0;
            quiet_r <= 6'h3f;
            last_t_r <= '0;
            unm_r <= 1'b0;
        end
        else
        begin
            tof_q <= tof_in;
            quiet_r <= (tof_in != tof_q) ? 6'h0 : (quiet_r == 6'h3f ? quiet_r : quiet_r + 6'h1);
            last_t_r <= meas_start ? '0 : (event_valid ? event_word[31:4] : last_t_r);
            unm_r <= rd_take && unm_addr;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_READY:
        assert property (hreadyout) else $error("hreadyout low");
    AST_OKAY:
        assert property (!hresp) else $error("error response");
    AST_UNMAPPED:
        assert property (unm_r |-> hrdata == 32'h0) else $error("unmapped read not zero");
    AST_CH_RANGE:
        assert property (event_valid |-> event_word[2:0] <= 3'h5) else $error("bad channel");
    AST_EVENT_CAUSE:
        assert property (event_valid |-> quiet_r < 6'd24) else $error("event without pin edge");
    AST_TIME_ORDER:
        assert property (event_valid && !meas_start |-> event_word[31:4] >= last_t_r) else $error("time went back");
    AST_START_RUN:
        assert property (meas_start |-> ##[1:4] meas_running) else $error("run not started");
    AST_PEAK_CAUSE:
        assert property (peak_valid |-> event_valid) else $error("peak without closing edge");
endmodule : tag_checker

bind edge_tag tag_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .tof_in, .meas_start, .event_valid, .event_word, .peak_valid, .meas_running);

// ### test/pulse_src.sv
// detector pulse source for the six time-of-flight pins
// assumes pins idle low and positive-going pulses
module pulse_src
(
    input wire logic hclk,
    output logic [5:0] tof_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial tof_in = 6'h0;
    task automatic pulse(input int ch, input int w);
        @(posedge hclk) tof_in[ch] <= 1'b1;
        repeat (w) @(posedge hclk);
        tof_in[ch] <= 1'b0;
        repeat (12) @(posedge hclk);
    endtask : pulse
endmodule : pulse_src

// ### test/tb.sv
// bench for edge_tag: queued capture of design events checked against expected values
// assumes zero-wait AHB-Lite slave and one time bin per hclk cycle
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tag_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, meas_start = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, event_word, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, event_valid, peak_valid, meas_running, irq;
    logic [TIME_W-1:0] peak_time;
    logic [NUM_IN-1:0] tof_in;
    logic [31:0] ev_q[$];
    logic [TIME_W-1:0] pk_q[$];
    int fails = 0, n_checks = 0, cyc = 0, t, t0;
    int dsteps[3] = '{1, 7, 15};
    always #2.5 hclk = ~hclk;
    edge_tag dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .tof_in, .meas_start, .event_valid, .event_word, .peak_time, .peak_valid, .meas_running, .irq);
    pulse_src src_u (.hclk, .tof_in);
    // ****************************************
    // monitor and helpers
    // ****************************************
    // capture outputs where they stand for one cycle
    always @(posedge hclk)
    begin
        cyc++;
        if (event_valid === 1'b1)
            ev_q.push_back(event_word);
        if (peak_valid === 1'b1)
            pk_q.push_back(peak_time);
        if (cyc == 30000)
        begin
            fails++;
            summarize();
        end
    end
    task automatic summarize();
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // address phase held to hready, data phase held to hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic start();
        @(posedge hclk) meas_start <= 1'b1;
        @(posedge hclk) meas_start <= 1'b0;
        repeat (4) @(posedge hclk);
        ev_q.delete();
        pk_q.delete();
    endtask : start
    // one pulse on the enabled pin, one on a disabled neighbour
    task automatic shot(input int ch, input logic [1:0] code, input int d, input int w, output int tr);
        int n;
        n = (code >= EDGE_BOTH) ? 2 : 1;
        wr(OFF_DELAY, d);
        wr(OFF_EDGE, 32'(code) << (2 * ch));
        wr(OFF_ENABLE, 32'h1 << ch);
        start();
        src_u.pulse(ch, w);
        src_u.pulse((ch + 1) % NUM_IN, w);
        repeat (10) @(posedge hclk);
        chk(ev_q.size(), n);
        for (int i = 0; i < ev_q.size(); i++)
        begin
            chk(32'(ev_q[i][2:0]), ch);
            chk(32'(ev_q[i][3]), 32'(code == EDGE_FALL || i == 1));
        end
        tr = ev_q.size() > 0 ? int'(ev_q[0][31:4]) : 0;
        if (n == 2)
            chk(32'(ev_q[1][31:4] - ev_q[0][31:4]), w);
    endtask : shot
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'h5493));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFF_ENABLE, 32'h0);
        rd(OFF_EDGE, 32'h0);
        rd(OFF_DELAY, 32'h0);
        rd(OFF_CTRL, CTRL_RESET);
        wr(8'h30, 32'hffff_ffff);
        rd(8'h30, 32'h0);
        // every input with every plain edge mode, random delay and width
        for (int ch = 0; ch < NUM_IN; ch++)
            for (int c = 0; c < 3; c++)
                shot(ch, 2'(c), $urandom % 16, 4 + $urandom % 12, t);
        // delay steps rounded up to whole cycles
        shot(2, EDGE_RISE, 0, 6, t0);
        foreach (dsteps[k])
        begin
            shot(2, EDGE_RISE, dsteps[k], 6, t);
            chk(32'(t - t0), 32'((dsteps[k] * 32 + 49) / 50));
        end
        // interrupt raised, masked, cleared
        wr(OFF_IRQ_STAT, 32'h7);
        wr(OFF_IRQ_MASK, 32'h0);
        start();
        chk(32'(irq), 32'h0);
        wr(OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0);
        rd(OFF_IRQ_STAT, 32'h0);
        // peak at half width for ratio one, then a too-wide pair
        wr(OFF_CTRL, 32'h1 << 9);
        wr(OFF_CFT, {24'h64, 8'h10});
        shot(1, EDGE_CFT, 0, 10, t);
        chk(pk_q.size(), 1);
        chk(32'(pk_q[0]), t + 5);
        wr(OFF_IRQ_STAT, 32'h7);
        wr(OFF_CFT, {24'h5, 8'h10});
        shot(1, EDGE_CFT, 0, 10, t);
        chk(pk_q.size(), 0);
        rd(OFF_IRQ_STAT, 32'h5);
        // region preset of one stops at the second counted event
        wr(OFF_CTRL, 32'h10);
        wr(8'h80, 32'h1);
        wr(8'h84, 32'h0);
        wr(8'h88, 32'h0fff_ffff);
        shot(4, EDGE_RISE, 0, 5, t);
        chk(32'(meas_running), 32'h1);
        src_u.pulse(4, 5);
        repeat (20) @(posedge hclk);
        chk(32'(meas_running), 32'h0);
        rd(8'h8c, 32'h2);
        // limits beyond any event time count nothing
        wr(8'h84, 32'h0fff_fff0);
        shot(4, EDGE_RISE, 0, 5, t);
        src_u.pulse(4, 5);
        repeat (20) @(posedge hclk);
        chk(32'(meas_running), 32'h1);
        rd(8'h8c, 32'h0);
        summarize();
    end
endmodule : tb
